// File: rtl/pfsb_pkg.sv
// constants, field tables and state type for the pin function select bank
package pfsb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_BANK3 = 12'h000;
  localparam logic [11:0] OFF_BANK5 = 12'h004;
  localparam logic [11:0] OFF_SEL0 = 12'h008;
  localparam logic [11:0] OFF_SEL7 = 12'h00c;
  localparam logic [11:0] OFF_SEL8 = 12'h010;
  localparam logic [11:0] OFF_SEL9 = 12'h014;
  localparam logic [11:0] OFF_SEL11 = 12'h018;
  localparam logic [11:0] OFF_SEL12 = 12'h01c;
  localparam logic [11:0] OFF_UNLOCK = 12'h020;
  localparam logic [11:0] OFF_STATUS = 12'h024;

  // word indices inside the select memory
  localparam logic [2:0] IDX_BANK3 = 3'h0;
  localparam logic [2:0] IDX_BANK5 = 3'h1;
  localparam logic [2:0] IDX_SEL0 = 3'h2;
  localparam int NUM_WORDS = 8;

  // ----------------------------------------------------------------
  // reset values, keys, field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] UNLOCK_KEY = 32'h5a5a_a5a5;
  localparam logic [31:0] SEL0_WRITE_MASK = 32'h7fff_ffff;
  localparam int STATUS_ARMED_BIT = 0;
  localparam int STATUS_REJECT_BIT = 1;
  localparam int ROUTED_PINS = 25;
  localparam int CODE_W = 3;

  // select word, low bit and width of the field that serves each bank pin
  localparam int B3_REG [ROUTED_PINS] = '{
    3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3,
    4, 4, 4, 4, 4, 4, 4, 4, 4, 4, 4,
    5, 5, 5};
  localparam int B3_LO [ROUTED_PINS] = '{
    3, 6, 9, 11, 13, 15, 17, 19, 21, 24, 27,
    0, 3, 6, 9, 12, 15, 18, 21, 24, 26, 28,
    0, 3, 6};
  localparam int B3_W [ROUTED_PINS] = '{
    3, 3, 2, 2, 2, 2, 2, 2, 3, 3, 3,
    3, 3, 3, 3, 3, 3, 3, 3, 2, 2, 3,
    3, 3, 1};
  localparam int B5_REG [ROUTED_PINS] = '{
    6, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6,
    7, 7, 7, 7, 7, 7, 7, 7, 7, 7};
  localparam int B5_LO [ROUTED_PINS] = '{
    9, 12, 15, 17, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 30,
    0, 2, 4, 7, 10, 13, 16, 18, 20, 22};
  localparam int B5_W [ROUTED_PINS] = '{
    3, 3, 2, 2, 1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2,
    2, 2, 3, 3, 3, 3, 2, 2, 2, 2};

  // ----------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic armed;
    logic rejected;
    logic [31:0] bank3;
    logic [31:0] bank5;
    logic [31:0] sel0;
    logic [ROUTED_PINS*CODE_W-1:0] bank3_code;
    logic [ROUTED_PINS*CODE_W-1:0] bank5_code;
  } pfsb_state_t;

  function automatic logic [CODE_W-1:0] pfsb_field(input logic [31:0] word, input int lo,
                                                   input int width);
    logic [CODE_W-1:0] mask;
    mask = (width == 1) ? 3'h1 : (width == 2) ? 3'h3 : 3'h7;
    return CODE_W'(word >> lo) & mask;
  endfunction

endpackage

// File: rtl/pfsb_reg_if.sv
// carrier between the bus front end and the select word memory
`timescale 1ns/1ps
interface pfsb_reg_if;
  logic we;
  logic [2:0] widx;
  logic [31:0] wdata;
  logic [2:0] ridx;
  logic [31:0] rdata;
  logic [31:0] words [8];

  modport ctrl (output we, output widx, output wdata, output ridx, input rdata, input words);
  modport mem (input we, input widx, input wdata, input ridx, output rdata, output words);
endinterface

// File: rtl/pfsb_regfile.sv
// select word memory with registered read data
`timescale 1ns/1ps
module pfsb_regfile
  import pfsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pfsb_reg_if.mem rif
);

  logic [31:0] mem [NUM_WORDS];
  logic [31:0] rd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        mem[i] <= SEL_RESET;
      end
      rd <= SEL_RESET;
    end else begin
      if (rif.we) begin
        mem[rif.widx] <= rif.wdata;
      end
      rd <= mem[rif.ridx];
    end
  end

  always_comb begin
    rif.rdata = rd;
    for (int i = 0; i < NUM_WORDS; i++) begin
      rif.words[i] = mem[i];
    end
  end

endmodule

// File: rtl/pfsb_top.sv
// pin function select bank: apb registers, write unlock and pin routing
//
// Function
// - route bit 0 gives gpio, 1 gives peripheral
// - select registers 32-bit read/write (select0 bit 31 reads zero), reset zero
// - bank3 bits 0-10 use select7 fields
// - bank3 bits 11-21 use select8 fields
// - bank3 bits 22-24 use select9 fields
// - bank5 bits 0-14 use select11 fields
// - bank5 bits 15-24 use select12 fields
// - field code n selects function n plus one
`timescale 1ns/1ps
module pfsb_top
  import pfsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] bank3_route_bit,
  output logic [31:0] bank5_route_bit,
  output logic [31:0] select0_field,
  output logic [ROUTED_PINS*CODE_W-1:0] bank3_func_code,
  output logic [ROUTED_PINS*CODE_W-1:0] bank5_func_code
);

  // ----------------------------------------------------------------
  // state and memory
  // ----------------------------------------------------------------
  pfsb_state_t q;
  pfsb_state_t next_q;
  pfsb_reg_if rif ();

  pfsb_regfile u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif)
  );

  logic done;
  logic is_sel;
  logic is_unlock;
  logic is_status;
  logic mapped;
  logic [2:0] idx;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    idx = paddr[4:2];
    is_sel = (paddr[1:0] == 2'h0) && (paddr <= OFF_SEL12);
    is_unlock = (paddr == OFF_UNLOCK);
    is_status = (paddr == OFF_STATUS);
    mapped = is_sel || is_unlock || is_status;
    // access completes on the edge where pready is seen high
    done = psel && penable && q.pready;
  end

  // memory read is issued every cycle from the live address; the setup
  // edge loads it, so one wait state covers every access
  always_comb begin
    rif.ridx = idx;
    rif.we = done && pwrite && is_sel && q.armed;
    rif.widx = idx;
    rif.wdata = (idx == IDX_SEL0) ? (pwdata & SEL0_WRITE_MASK) : pwdata;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.pready = psel && penable && !q.pready;
    // read data and error stand only beside pready, zero otherwise
    next_q.pslverr = 1'b0;
    next_q.prdata = 32'h0000_0000;
    if (psel && penable && !q.pready) begin
      next_q.pslverr = !mapped;
      if (!pwrite) begin
        if (is_sel) begin
          next_q.prdata = rif.rdata;
        end else if (is_status) begin
          next_q.prdata[STATUS_ARMED_BIT] = q.armed;
          next_q.prdata[STATUS_REJECT_BIT] = q.rejected;
        end
      end
    end
    if (done) begin
      // unlock lasts only for the very next access of any kind
      next_q.armed = pwrite && is_unlock && (pwdata == UNLOCK_KEY);
      if (pwrite && is_sel) begin
        next_q.rejected = !q.armed;
      end
    end
    // pin routing follows the stored words one cycle after they change
    next_q.bank3 = rif.words[IDX_BANK3];
    next_q.bank5 = rif.words[IDX_BANK5];
    next_q.sel0 = rif.words[IDX_SEL0] & SEL0_WRITE_MASK;
    for (int i = 0; i < ROUTED_PINS; i++) begin
      // code 0 while the pin belongs to gpio
      next_q.bank3_code[i*CODE_W +: CODE_W] = rif.words[IDX_BANK3][i] ?
        pfsb_field(rif.words[B3_REG[i]], B3_LO[i], B3_W[i]) : 3'h0;
      next_q.bank5_code[i*CODE_W +: CODE_W] = rif.words[IDX_BANK5][i] ?
        pfsb_field(rif.words[B5_REG[i]], B5_LO[i], B5_W[i]) : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_comb begin
    prdata = q.prdata;
    pready = q.pready;
    pslverr = q.pslverr;
    bank3_route_bit = q.bank3;
    bank5_route_bit = q.bank5;
    select0_field = q.sel0;
    bank3_func_code = q.bank3_code;
    bank5_func_code = q.bank5_code;
  end

endmodule

// File: bench/pfsb_checker.sv
// assertions on the bus and routing ports of the pin function select bank
`timescale 1ns/1ps
module pfsb_checker
  import pfsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] bank3_route_bit,
  input wire logic [31:0] bank5_route_bit,
  input wire logic [31:0] select0_field,
  input wire logic [ROUTED_PINS*CODE_W-1:0] bank3_func_code,
  input wire logic [ROUTED_PINS*CODE_W-1:0] bank5_func_code
);
  logic armed;
  logic xfer;
  assign xfer = psel && penable && pready;
  // a key is good for the one access right after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (xfer) begin
      armed <= pwrite && paddr == OFF_UNLOCK && pwdata == UNLOCK_KEY;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_wait;
    psel && penable && !pready;
  endsequence
  sequence answer_once;
    pready ##1 !pready;
  endsequence
  access_len_a: assert property (access_wait |=> answer_once)
    else $error("access phase length wrong");
  read_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  sel0_top_zero_a: assert property (select0_field[31] == 1'b0)
    else $error("select0 bit 31 set");
  gpio3_code_a: assert property (!bank3_route_bit[10] |-> bank3_func_code[32:30] == 3'h0)
    else $error("gpio pin carries a code");
  gpio5_code_a: assert property (!bank5_route_bit[14] |-> bank5_func_code[44:42] == 3'h0)
    else $error("gpio pin carries a code");
  locked_hold_a: assert property ((xfer && pwrite && paddr == OFF_BANK3 && !armed)
    |=> $stable(bank3_route_bit)[*2]) else $error("locked write changed routing");
  bank3_take_a: assert property ((xfer && pwrite && paddr == OFF_BANK3 && armed)
    |=> ##1 bank3_route_bit == $past(pwdata, 2)) else $error("routing not taken");
  sel0_take_a: assert property ((xfer && pwrite && paddr == OFF_SEL0 && armed)
    |=> ##1 select0_field == ($past(pwdata, 2) & SEL0_WRITE_MASK)) else $error("select0 wrong");
endmodule

bind pfsb_top pfsb_checker pfsb_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .bank3_route_bit, .bank5_route_bit, .select0_field,
  .bank3_func_code, .bank5_func_code);

// File: bench/pfsb_periph_model.sv
// pin owner as seen by the peripherals and gpio sharing one routed pin
`timescale 1ns/1ps
module pfsb_periph_model
  import pfsb_pkg::*;
(
  input wire logic [31:0] bank3_route_bit,
  input wire logic [31:0] bank5_route_bit,
  input wire logic [ROUTED_PINS*CODE_W-1:0] bank3_func_code,
  input wire logic [ROUTED_PINS*CODE_W-1:0] bank5_func_code,
  input wire logic use5,
  input wire logic [4:0] pin,
  output logic [3:0] owner
);
  logic [2:0] code;
  // owner 0 is the gpio port, n+1 the peripheral picked by code n
  always_comb begin
    code = use5 ? bank5_func_code[pin*3 +: 3] : bank3_func_code[pin*3 +: 3];
    owner = 4'(code) + 4'h1;
    if (!(use5 ? bank5_route_bit[pin] : bank3_route_bit[pin])) begin
      owner = 4'h0;
    end
  end
endmodule

// File: bench/pfsb_tb_top.sv
// self-checking bench for the pin function select bank
`timescale 1ns/1ps
module pfsb_tb_top;
  import pfsb_pkg::*;
  typedef struct {logic [11:0] off; int pin; int lo; int w;} pfsb_ent_t;
  pfsb_ent_t tab[11] = '{'{OFF_SEL7, 0, 3, 3}, '{OFF_SEL7, 10, 27, 3}, '{OFF_SEL8, 11, 0, 3},
    '{OFF_SEL8, 21, 28, 3}, '{OFF_SEL9, 22, 0, 3}, '{OFF_SEL9, 23, 3, 3}, '{OFF_SEL9, 24, 6, 1},
    '{OFF_SEL11, 0, 9, 3}, '{OFF_SEL11, 14, 30, 2}, '{OFF_SEL12, 15, 0, 2}, '{OFF_SEL12, 24, 22, 2}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic use5 = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, bank3_route_bit, bank5_route_bit, select0_field, rd;
  logic pready, pslverr, err;
  logic [ROUTED_PINS*CODE_W-1:0] bank3_func_code, bank5_func_code;
  logic [4:0] pin = 5'h00;
  logic [3:0] owner;
  int failures = 0;
  int cmp_count = 0;
  int k;
  always #2.5 pclk = ~pclk;
  pfsb_top pfsb_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bank3_route_bit, .bank5_route_bit, .select0_field, .bank3_func_code,
    .bank5_func_code);
  pfsb_periph_model pfsb_periph_model_inst (.bank3_route_bit, .bank5_route_bit, .bank3_func_code,
    .bank5_func_code, .use5, .pin, .owner);
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; returns one edge after release
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic uw(input logic [11:0] a, input logic [31:0] d);
    apb(OFF_UNLOCK, 1'b1, UNLOCK_KEY);
    apb(a, 1'b1, d);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // no thermal outputs are grounded here, so no idle write is owed
    apb(OFF_BANK3, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h0);
    apb(OFF_BANK5, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(OFF_SEL0, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(bank3_route_bit | bank5_route_bit, 32'h0);
    uw(OFF_BANK3, 32'h01ff_ffff);
    uw(OFF_BANK5, 32'h01ff_ffff);
    apb(OFF_BANK3, 1'b0, 32'h0);
    chk(rd, 32'h01ff_ffff);
    chk(bank3_route_bit, 32'h01ff_ffff);
    foreach (tab[i]) begin
      k = tab[i].w == 1 ? 1 : tab[i].w == 2 ? 2 : 5;
      use5 <= tab[i].off >= OFF_SEL11;
      pin <= 5'(tab[i].pin);
      uw(tab[i].off, 32'(k) << tab[i].lo);
      repeat (2) @(posedge pclk);
      chk(32'((use5 ? bank5_func_code : bank3_func_code) >> (tab[i].pin * 3)) & 32'h7, k);
      chk(32'(owner), 32'(k + 1));
    end
    // a bare write, then a key spent on a read, must both leave bank5 alone
    apb(OFF_BANK5, 1'b1, 32'h0);
    apb(OFF_BANK3, 1'b1, 32'h0);
    apb(OFF_BANK5, 1'b0, 32'h0);
    chk(rd, 32'h01ff_ffff);
    chk(bank3_route_bit, 32'h01ff_ffff);
    apb(OFF_UNLOCK, 1'b1, UNLOCK_KEY);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(OFF_BANK5, 1'b1, 32'h0);
    apb(OFF_BANK5, 1'b0, 32'h0);
    chk(rd, 32'h01ff_ffff);
    uw(OFF_SEL0, 32'hffff_ffff);
    apb(OFF_SEL0, 1'b0, 32'h0);
    chk(rd, 32'h7fff_ffff);
    chk(select0_field, 32'h7fff_ffff);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0000);
    use5 <= 1'b0;
    pin <= 5'h0a;
    uw(OFF_BANK3, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(owner), 32'h0);
    apb(12'h0ff, 1'b0, 32'h0);
    chk(32'(err), 32'h1);
    wrap_up();
  end
endmodule
